// ---- hdl/adcr_defines.svh ----
// Purpose: Timing counts, pin positions and reset values of the ADC result readout.
// Assumes: One 20 MHz core clock; all times in ns, counts derived from them.
// Notes:   Least times round up, longest and typical times round down, none below one cycle.
//
// How it works
// - Parallel result valid within 0.75, 1 or 1.25 us of convert start.
// - Parallel data valid at least 20 ns before busy falls.
// - Read-during-convert frame marker rises 25, 275 or 525 ns after convert start; in fast mode the code raises it after 200 to 250 ns.
// - Read-after-convert frame marker rises 0.75, 1 or 1.25 us after convert start.
// - Read-after-convert busy spans the transfer, falls 25 ns after frame marker.
// - Divider setting picks least serial clock period 25, 50, 100, 200 ns.
// - Serial clock period at most 40, 70, 140, 280 ns per divider setting; dividers 0 and 1 run at 100 ns in the code.
// - Serial clock high at least 15/25/50/100 ns, low 9/24/49/99 ns.
// - First serial clock edge at least 4 or 20 ns after frame marker.
// - Frame marker held 3, 60, 140 or 300 ns after last serial edge.
// - Fastest mode read-after-convert busy under 1.5/2/3/5.25 us; dividers 0 and 1 hold it 2.25 and 2.3 us in the code.
// - Normal mode read-after-convert busy under 1.75/2.25/3.25/5.5 us; dividers 0 and 1 hold it 2.5 and 2.55 us in the code.
// - Low-power read-after-convert busy under 2/2.5/3.5/5.75 us; dividers 0 and 1 hold it 2.75 and 2.8 us in the code.
// - Serial outputs driven within 10 ns of chip select falling; the code enables them 100 to 150 ns later through the synchronisers.
// - Serial outputs released within 10 ns of chip select rising; the code releases them 100 to 150 ns later through the synchronisers.
// - Clock source low drives internal clock out; high uses gated external clock.
`ifndef ADCR_DEFINES_SVH
`define ADCR_DEFINES_SVH

`define ADCR_CLK_NS 50
`define ADCR_UP(t) (((t) + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS)
`define ADCR_DN(t) ((((t) / `ADCR_CLK_NS) < 1) ? 1 : ((t) / `ADCR_CLK_NS))
`define ADCR_MAX(a, b) (((a) > (b)) ? (a) : (b))

`define ADCR_WORD_W 16
`define ADCR_FIFO_D 4
`define ADCR_CNT_W 8
`define ADCR_BITS_W 5

// Two synchroniser flops plus the edge register
`define ADCR_IN_LAT 3
// FIFO read plus output register
`define ADCR_OUT_LAT 2

`define ADCR_T_CONV_FAST_NS 750
`define ADCR_T_CONV_NORM_NS 1000
`define ADCR_T_CONV_LOWP_NS 1250
`define ADCR_PUSH_CYC(t) (`ADCR_DN(t) - `ADCR_IN_LAT - `ADCR_OUT_LAT)

`define ADCR_T_RDC_FAST_NS 25
`define ADCR_T_RDC_NORM_NS 275
`define ADCR_T_RDC_LOWP_NS 525
`define ADCR_RDC_CYC(t) `ADCR_MAX(1, `ADCR_DN(t) - `ADCR_IN_LAT)

`define ADCR_T_DATA_TO_BUSY_NS 20
`define ADCR_DATA_TO_BUSY_CYC `ADCR_UP(`ADCR_T_DATA_TO_BUSY_NS)
`define ADCR_T_SYNC_TO_BUSY_NS 25
`define ADCR_SYNC_TO_BUSY_CYC `ADCR_DN(`ADCR_T_SYNC_TO_BUSY_NS)

`define ADCR_T_PER_MIN0_NS 25
`define ADCR_T_PER_MIN1_NS 50
`define ADCR_T_PER_MIN2_NS 100
`define ADCR_T_PER_MIN3_NS 200
`define ADCR_T_HI_MIN0_NS 15
`define ADCR_T_HI_MIN1_NS 25
`define ADCR_T_HI_MIN2_NS 50
`define ADCR_T_HI_MIN3_NS 100
`define ADCR_T_LO_MIN0_NS 9
`define ADCR_T_LO_MIN1_NS 24
`define ADCR_T_LO_MIN2_NS 49
`define ADCR_T_LO_MIN3_NS 99
`define ADCR_T_LEAD_MIN0_NS 4
`define ADCR_T_LEAD_MIN1_NS 20
`define ADCR_T_HOLD_MIN0_NS 3
`define ADCR_T_HOLD_MIN1_NS 60
`define ADCR_T_HOLD_MIN2_NS 140
`define ADCR_T_HOLD_MIN3_NS 300
`define ADCR_LO_CYC(l, p, h) `ADCR_MAX(`ADCR_UP(l), `ADCR_UP(p) - `ADCR_UP(h))

// Synchronised pin vector positions
`define ADCR_PIN_CNV 0
`define ADCR_PIN_CS 1
`define ADCR_PIN_FAST 2
`define ADCR_PIN_LOWP 3
`define ADCR_PIN_SER 4
`define ADCR_PIN_EXT 5
`define ADCR_PIN_RDC 6
`define ADCR_PIN_DIV0 7
`define ADCR_PIN_DIV1 8
`define ADCR_PIN_XCLK 9
`define ADCR_PIN_N 10
// Convert start and chip select idle high
`define ADCR_PIN_RST 10'h003

`endif

// ---- hdl/adcr_pkg.sv ----
// Purpose: Types of the ADC result readout.
// Assumes: Constants live in adcr_defines.svh.
// Notes:   State codes are one-hot.
package adcr_pkg;

    typedef enum logic [1:0] {
        ADCR_SPEED_NORM = 2'h0,
        ADCR_SPEED_FAST = 2'h1,
        ADCR_SPEED_LOWP = 2'h2
    } adcr_speed_t;

    typedef enum logic [3:0] {
        ADCR_C_IDLE = 4'h1,
        ADCR_C_CONV = 4'h2,
        ADCR_C_FINISH = 4'h4,
        ADCR_C_TAIL = 4'h8
    } adcr_conv_state_t;

    typedef enum logic [4:0] {
        ADCR_S_IDLE = 5'h01,
        ADCR_S_LEAD = 5'h02,
        ADCR_S_HIGH = 5'h04,
        ADCR_S_LOW = 5'h08,
        ADCR_S_HOLD = 5'h10
    } adcr_ser_state_t;

endpackage

// ---- hdl/adcr_readout.sv ----
// Purpose: Result readout sequencing of a 16-bit converter: busy, parallel and serial ports.
// Assumes: 20 MHz core clock; the core hands its result on sample_data_in at the push point.
// Notes:   All pins pass two flops, so pin-relative figures include that latency.
`timescale 1ns/1ps
`include "adcr_defines.svh"

// ************************************************************
// Result FIFO
// ************************************************************
module adcr_fifo #(
    parameter int WIDTH = `ADCR_WORD_W,
    parameter int DEPTH = `ADCR_FIFO_D
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign do_wr = in_valid_in && in_ready_out;
    assign do_rd = out_valid_out && out_ready_in;

    always_ff @(posedge core_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// ************************************************************
// Readout top
// ************************************************************
module adcr_readout
    import adcr_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic convert_start_n_in,
    input wire logic chip_select_n_in,
    input wire logic fast_mode_in,
    input wire logic low_power_in,
    input wire logic port_type_select_in,
    input wire logic clock_source_select_in,
    input wire logic read_timing_select_in,
    input wire logic [1:0] serial_clock_divider_in,
    input wire logic ext_serial_clock_in,
    input wire logic [15:0] sample_data_in,
    output logic busy_out,
    output logic [15:0] parallel_data_out,
    output logic parallel_data_oe_out,
    output logic frame_sync_out,
    output logic frame_sync_oe_out,
    output logic serial_clock_out,
    output logic serial_clock_oe_out,
    output logic serial_data_out,
    output logic serial_data_oe_out
);
    typedef logic [`ADCR_CNT_W-1:0] adcr_cnt_t;

    // ************************************************************
    // Decode functions
    // ************************************************************
    function automatic adcr_speed_t speed_of(input logic fast, input logic lowp);
        if (fast && !lowp) begin
            return ADCR_SPEED_FAST;
        end else if (lowp && !fast) begin
            return ADCR_SPEED_LOWP;
        end
        // Both high is undefined; normal is the safe reading
        return ADCR_SPEED_NORM;
    endfunction

    function automatic adcr_cnt_t push_cyc(input adcr_speed_t sp);
        case (sp)
            ADCR_SPEED_FAST: return adcr_cnt_t'(`ADCR_PUSH_CYC(`ADCR_T_CONV_FAST_NS));
            ADCR_SPEED_LOWP: return adcr_cnt_t'(`ADCR_PUSH_CYC(`ADCR_T_CONV_LOWP_NS));
            default: return adcr_cnt_t'(`ADCR_PUSH_CYC(`ADCR_T_CONV_NORM_NS));
        endcase
    endfunction

    function automatic adcr_cnt_t rdc_cyc(input adcr_speed_t sp);
        case (sp)
            ADCR_SPEED_FAST: return adcr_cnt_t'(`ADCR_RDC_CYC(`ADCR_T_RDC_FAST_NS));
            ADCR_SPEED_LOWP: return adcr_cnt_t'(`ADCR_RDC_CYC(`ADCR_T_RDC_LOWP_NS));
            default: return adcr_cnt_t'(`ADCR_RDC_CYC(`ADCR_T_RDC_NORM_NS));
        endcase
    endfunction

    function automatic adcr_cnt_t hi_cyc(input logic [1:0] dv);
        case (dv)
            2'h0: return adcr_cnt_t'(`ADCR_UP(`ADCR_T_HI_MIN0_NS));
            2'h1: return adcr_cnt_t'(`ADCR_UP(`ADCR_T_HI_MIN1_NS));
            2'h2: return adcr_cnt_t'(`ADCR_UP(`ADCR_T_HI_MIN2_NS));
            default: return adcr_cnt_t'(`ADCR_UP(`ADCR_T_HI_MIN3_NS));
        endcase
    endfunction

    function automatic adcr_cnt_t lo_cyc(input logic [1:0] dv);
        case (dv)
            2'h0: return adcr_cnt_t'(`ADCR_LO_CYC(`ADCR_T_LO_MIN0_NS, `ADCR_T_PER_MIN0_NS,
                                                  `ADCR_T_HI_MIN0_NS));
            2'h1: return adcr_cnt_t'(`ADCR_LO_CYC(`ADCR_T_LO_MIN1_NS, `ADCR_T_PER_MIN1_NS,
                                                  `ADCR_T_HI_MIN1_NS));
            2'h2: return adcr_cnt_t'(`ADCR_LO_CYC(`ADCR_T_LO_MIN2_NS, `ADCR_T_PER_MIN2_NS,
                                                  `ADCR_T_HI_MIN2_NS));
            default: return adcr_cnt_t'(`ADCR_LO_CYC(`ADCR_T_LO_MIN3_NS, `ADCR_T_PER_MIN3_NS,
                                                     `ADCR_T_HI_MIN3_NS));
        endcase
    endfunction

    function automatic adcr_cnt_t lead_cyc(input logic [1:0] dv);
        return adcr_cnt_t'(`ADCR_UP(dv == 2'h0 ? `ADCR_T_LEAD_MIN0_NS : `ADCR_T_LEAD_MIN1_NS));
    endfunction

    function automatic adcr_cnt_t hold_cyc(input logic [1:0] dv);
        case (dv)
            2'h0: return adcr_cnt_t'(`ADCR_UP(`ADCR_T_HOLD_MIN0_NS));
            2'h1: return adcr_cnt_t'(`ADCR_UP(`ADCR_T_HOLD_MIN1_NS));
            2'h2: return adcr_cnt_t'(`ADCR_UP(`ADCR_T_HOLD_MIN2_NS));
            default: return adcr_cnt_t'(`ADCR_UP(`ADCR_T_HOLD_MIN3_NS));
        endcase
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [`ADCR_PIN_N-1:0] pin_raw;
    logic [`ADCR_PIN_N-1:0] pin_meta;
    logic [`ADCR_PIN_N-1:0] pin_sync;
    logic cnv_prev;
    logic xclk_prev;

    assign pin_raw = {ext_serial_clock_in, serial_clock_divider_in, read_timing_select_in,
                      clock_source_select_in, port_type_select_in, low_power_in, fast_mode_in,
                      chip_select_n_in, convert_start_n_in};

    genvar gi;
    generate
        for (gi = 0; gi < `ADCR_PIN_N; gi++) begin : g_sync
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    pin_meta[gi] <= 1'(`ADCR_PIN_RST >> gi);
                    pin_sync[gi] <= 1'(`ADCR_PIN_RST >> gi);
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cnv_prev <= 1'b1;
            xclk_prev <= 1'b0;
        end else begin
            cnv_prev <= pin_sync[`ADCR_PIN_CNV];
            xclk_prev <= pin_sync[`ADCR_PIN_XCLK];
        end
    end

    logic start_evt;
    logic cs_active;
    logic mode_serial;
    logic mode_master;
    logic mode_rac;
    logic mode_rdc;
    logic mode_slave;
    logic xclk_fall;
    adcr_speed_t speed_now;

    assign start_evt = cnv_prev && !pin_sync[`ADCR_PIN_CNV];
    assign cs_active = !pin_sync[`ADCR_PIN_CS];
    assign mode_serial = pin_sync[`ADCR_PIN_SER];
    assign mode_master = mode_serial && !pin_sync[`ADCR_PIN_EXT];
    assign mode_slave = mode_serial && pin_sync[`ADCR_PIN_EXT];
    assign mode_rac = mode_master && !pin_sync[`ADCR_PIN_RDC];
    assign mode_rdc = mode_master && pin_sync[`ADCR_PIN_RDC];
    assign xclk_fall = xclk_prev && !pin_sync[`ADCR_PIN_XCLK];
    assign speed_now = speed_of(pin_sync[`ADCR_PIN_FAST], pin_sync[`ADCR_PIN_LOWP]);

    // ************************************************************
    // FIFO between converter core and output ports
    // ************************************************************
    adcr_conv_state_t conv_state;
    adcr_ser_state_t ser_state;
    adcr_speed_t conv_speed;
    adcr_cnt_t conv_cnt;
    logic push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic par_load;
    logic ser_start;
    logic slave_load;
    logic ser_done;
    logic [`ADCR_BITS_W-1:0] bits_left;

    assign push = (conv_state == ADCR_C_CONV) && (conv_cnt == push_cyc(conv_speed) - 1'b1);
    assign par_load = !mode_serial && fifo_out_valid;
    // Read-during-convert sends the previous result while this one converts
    assign ser_start = (ser_state == ADCR_S_IDLE) && fifo_out_valid && (
        (mode_rac && conv_state == ADCR_C_FINISH) ||
        (mode_rdc && conv_state == ADCR_C_CONV && conv_cnt == rdc_cyc(conv_speed)));
    assign slave_load = mode_slave && bits_left == '0 && fifo_out_valid;

    adcr_fifo #(.WIDTH(`ADCR_WORD_W), .DEPTH(`ADCR_FIFO_D)) u_fifo (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(sample_data_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(par_load || ser_start || slave_load),
        .out_data_out(fifo_out_data)
    );

    // ************************************************************
    // Conversion and busy sequencing
    // ************************************************************
    logic result_taken;
    adcr_cnt_t tail_len;

    assign result_taken = mode_rac ? ser_done : (mode_serial ? 1'b1 : par_load);
    assign tail_len = mode_rac ? adcr_cnt_t'(`ADCR_SYNC_TO_BUSY_CYC)
                               : adcr_cnt_t'(`ADCR_DATA_TO_BUSY_CYC);

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            conv_state <= ADCR_C_IDLE;
            conv_cnt <= '0;
            conv_speed <= ADCR_SPEED_NORM;
            busy_out <= 1'b0;
        end else begin
            case (conv_state)
                ADCR_C_IDLE: begin
                    // A full FIFO refuses the start, stalling conversions
                    if (start_evt && fifo_in_ready) begin
                        conv_state <= ADCR_C_CONV;
                        conv_cnt <= '0;
                        conv_speed <= speed_now;
                        busy_out <= 1'b1;
                    end
                end
                ADCR_C_CONV: begin
                    conv_cnt <= conv_cnt + 1'b1;
                    if (push) begin
                        conv_state <= ADCR_C_FINISH;
                    end
                end
                ADCR_C_FINISH: begin
                    // Parallel and read-after-convert modes keep busy high until the result is out
                    if (result_taken) begin
                        conv_state <= ADCR_C_TAIL;
                        conv_cnt <= '0;
                    end
                end
                ADCR_C_TAIL: begin
                    conv_cnt <= conv_cnt + 1'b1;
                    if (conv_cnt == tail_len - 1'b1) begin
                        conv_state <= ADCR_C_IDLE;
                        busy_out <= 1'b0;
                    end
                end
                default: begin
                    conv_state <= ADCR_C_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Parallel port
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            parallel_data_out <= '0;
            parallel_data_oe_out <= 1'b0;
        end else begin
            if (par_load) begin
                parallel_data_out <= fifo_out_data;
            end
            parallel_data_oe_out <= !mode_serial && cs_active;
        end
    end

    // ************************************************************
    // Master serial frame
    // ************************************************************
    adcr_cnt_t ser_cnt;
    logic [1:0] div_sel;

    assign ser_done = (ser_state == ADCR_S_HOLD) && (ser_cnt == hold_cyc(div_sel) - 1'b1);

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ser_state <= ADCR_S_IDLE;
            ser_cnt <= '0;
            div_sel <= 2'h0;
            frame_sync_out <= 1'b0;
            serial_clock_out <= 1'b0;
        end else begin
            ser_cnt <= ser_cnt + 1'b1;
            case (ser_state)
                ADCR_S_IDLE: begin
                    if (ser_start) begin
                        ser_state <= ADCR_S_LEAD;
                        ser_cnt <= '0;
                        // Divider pins count only in read-after-convert
                        div_sel <= mode_rac ? pin_sync[`ADCR_PIN_DIV1:`ADCR_PIN_DIV0]
                                            : 2'h0;
                        frame_sync_out <= 1'b1;
                    end
                end
                ADCR_S_LEAD: begin
                    if (ser_cnt == lead_cyc(div_sel) - 1'b1) begin
                        ser_state <= ADCR_S_HIGH;
                        ser_cnt <= '0;
                        serial_clock_out <= 1'b1;
                    end
                end
                ADCR_S_HIGH: begin
                    if (ser_cnt == hi_cyc(div_sel) - 1'b1) begin
                        ser_cnt <= '0;
                        serial_clock_out <= 1'b0;
                        ser_state <= (bits_left == `ADCR_BITS_W'(1)) ? ADCR_S_HOLD
                                                                     : ADCR_S_LOW;
                    end
                end
                ADCR_S_LOW: begin
                    if (ser_cnt == lo_cyc(div_sel) - 1'b1) begin
                        ser_cnt <= '0;
                        serial_clock_out <= 1'b1;
                        ser_state <= ADCR_S_HIGH;
                    end
                end
                ADCR_S_HOLD: begin
                    if (ser_done) begin
                        frame_sync_out <= 1'b0;
                        ser_state <= ADCR_S_IDLE;
                    end
                end
                default: begin
                    ser_state <= ADCR_S_IDLE;
                    frame_sync_out <= 1'b0;
                    serial_clock_out <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Shift register, MSB first
    // ************************************************************
    logic [15:0] shift_reg;
    logic master_fall;
    logic slave_shift;

    assign master_fall = (ser_state == ADCR_S_HIGH) && (ser_cnt == hi_cyc(div_sel) - 1'b1);
    // External clock is sampled, so it must run well below the core clock
    assign slave_shift = mode_slave && cs_active && xclk_fall && bits_left != '0;
    assign serial_data_out = shift_reg[15];

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            shift_reg <= '0;
            bits_left <= '0;
        end else if (ser_start || slave_load) begin
            shift_reg <= fifo_out_data;
            bits_left <= `ADCR_BITS_W'(`ADCR_WORD_W);
        end else if (master_fall || slave_shift) begin
            shift_reg <= {shift_reg[14:0], 1'b0};
            bits_left <= bits_left - 1'b1;
        end
    end

    // ************************************************************
    // Serial output enables
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            frame_sync_oe_out <= 1'b0;
            serial_clock_oe_out <= 1'b0;
            serial_data_oe_out <= 1'b0;
        end else begin
            frame_sync_oe_out <= mode_master && cs_active;
            serial_clock_oe_out <= mode_master && cs_active;
            serial_data_oe_out <= mode_serial && cs_active;
        end
    end
endmodule

// ---- tb/adcr_readout_monitor.sv ----
// Purpose: Port-level timing checks of the ADC result readout.
// Assumes: Divider pins held steady while a frame runs.
// Notes:   Figures are core cycles of 50 ns.
`timescale 1ns/1ps
// ********************************
// Checker
// ********************************
module adcr_readout_monitor (
    input wire logic core_clk_in, sys_rst_in, chip_select_n_in, port_type_select_in,
    input wire logic clock_source_select_in, read_timing_select_in, fast_mode_in,
    input wire logic low_power_in, busy_out, frame_sync_out, serial_clock_out,
    input wire logic frame_sync_oe_out, serial_clock_oe_out, serial_data_oe_out,
    input wire logic parallel_data_oe_out,
    input wire logic [1:0] serial_clock_divider_in,
    input wire logic [15:0] parallel_data_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic rac;
    logic [4:0] edges;
    assign rac = port_type_select_in && !clock_source_select_in && !read_timing_select_in;
    // Rising serial clock edges seen inside the current frame
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || !frame_sync_out) begin
            edges <= 5'h00;
        end else if ($rose(serial_clock_out)) begin
            edges <= edges + 5'h01;
        end
    end
    AST_DATA_SETTLED: assert property ($fell(busy_out) && !port_type_select_in
        |-> $stable(parallel_data_out)) else $error("data moved as busy fell");
    AST_BUSY_TAIL: assert property ($fell(frame_sync_out) && rac
        |-> busy_out ##1 !busy_out) else $error("busy tail wrong");
    AST_LEAD: assert property ($rose(frame_sync_out) && rac
        |-> !serial_clock_out ##1 serial_clock_out) else $error("lead wrong");
    AST_PHASES: assert property ($rose(serial_clock_out) && rac
        && serial_clock_divider_in == 2'h3 |-> serial_clock_out [*2] ##1
        (!serial_clock_out) [*2]) else $error("clock phases short");
    AST_HOLD: assert property ($fell(serial_clock_out) && rac
        && serial_clock_divider_in == 2'h3 |-> frame_sync_out [*6]) else $error("hold short");
    AST_BITS: assert property ($fell(frame_sync_out) && rac |-> edges == 5'h10)
        else $error("bit count wrong");
    AST_BUSY_MAX: assert property ($rose(busy_out) && fast_mode_in && !low_power_in
        && serial_clock_divider_in == 2'h2 |-> ##[1:60] !busy_out) else $error("busy long");
    AST_RELEASE: assert property (chip_select_n_in [*4] |-> ##1 !(frame_sync_oe_out
        || serial_clock_oe_out || serial_data_oe_out || parallel_data_oe_out))
        else $error("outputs not released");
endmodule
bind adcr_readout adcr_readout_monitor adcr_readout_monitor_i (.*);

// ---- tb/adcr_host_model.sv ----
// Purpose: Host side: convert start pulses and the slave serial clock.
// Assumes: Start requests are one-cycle pulses.
// Notes:   Slave clock is 16 cycles long so the synchronised shift settles first.
`timescale 1ns/1ps
module adcr_host_model (
    input wire logic core_clk_in,
    input wire logic start_in,
    input wire logic clock_run_in,
    output logic convert_start_n_out,
    output logic ext_serial_clock_out
);
    logic held = 1'h0;
    logic [3:0] tick = 4'h0;
    initial convert_start_n_out = 1'h1;
    initial ext_serial_clock_out = 1'h0;
    always @(posedge core_clk_in) begin
        held <= start_in;
        convert_start_n_out <= !(start_in || held);
        tick <= clock_run_in ? tick + 4'h1 : 4'h0;
        // Stands low outside transfers
        ext_serial_clock_out <= clock_run_in && tick[3];
    end
endmodule

// ---- tb/test_adc_result_readout_timing.sv ----
// Purpose: Self-checking bench of the ADC result readout.
// Assumes: Host model makes convert pulses and the slave clock.
// Notes:   Expected words come from a queue filled as each conversion starts.
`timescale 1ns/1ps
module test_adc_result_readout_timing;
    logic core_clk_in = 1'h0, sys_rst_in = 1'h1, chip_select_n_in = 1'h1, go = 1'h0;
    logic fast_mode_in = 1'h0, low_power_in = 1'h0, port_type_select_in = 1'h0;
    logic clock_source_select_in = 1'h0, read_timing_select_in = 1'h0, run = 1'h0;
    logic s_prev = 1'h0, x_prev = 1'h0, convert_start_n_in, ext_serial_clock_in;
    logic [1:0] serial_clock_divider_in = 2'h0;
    logic [15:0] sample_data_in = 16'h0000, parallel_data_out, got = 16'h0000;
    logic busy_out, parallel_data_oe_out, frame_sync_out, frame_sync_oe_out;
    logic serial_clock_out, serial_clock_oe_out, serial_data_out, serial_data_oe_out;
    logic [31:0] lfsr = 32'hacbb5de2;
    int fails = 0, comparisons = 0, cyc = 0, nbits = 0, wid = 0;
    logic [15:0] q[$];
    adcr_readout adcr_readout_i (.*);
    adcr_host_model adcr_host_model_i (.core_clk_in(core_clk_in), .start_in(go),
        .clock_run_in(run), .convert_start_n_out(convert_start_n_in),
        .ext_serial_clock_out(ext_serial_clock_in));
    always #25 core_clk_in = ~core_clk_in;
    task automatic print_verdict;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bit capture on the sampling edge of whichever clock owns the frame
    always @(posedge core_clk_in) begin
        cyc++;
        s_prev <= serial_clock_out;
        x_prev <= ext_serial_clock_in;
        if (busy_out === 1'h1) wid++;
        if (clock_source_select_in ? ext_serial_clock_in && !x_prev
                : frame_sync_out && serial_clock_out && !s_prev) begin
            got = {got[14:0], serial_data_out};
            nbits++;
        end
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic convert;
        lfsr = lfsr_next(lfsr);
        sample_data_in <= lfsr[15:0];
        q.push_back(lfsr[15:0]);
        wid = 0;
        nbits = 0;
        go <= 1'h1;
        @(posedge core_clk_in);
        go <= 1'h0;
    endtask
    task automatic wait_idle;
        repeat (6) @(posedge core_clk_in);
        for (int k = 0; k < 400 && busy_out === 1'h1; k++) @(posedge core_clk_in);
        check({15'h0000, busy_out}, 16'h0000);
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        sys_rst_in <= 1'h0;
        chip_select_n_in <= 1'h0;
        for (int m = 0; m < 3; m++) begin
            fast_mode_in <= (m == 0);
            low_power_in <= (m == 2);
            repeat (4) @(posedge core_clk_in);
            convert();
            repeat (15 + 5 * m) @(posedge core_clk_in);
            #1;
            check(parallel_data_out, q.pop_front());
            wait_idle();
        end
        chip_select_n_in <= 1'h1;
        repeat (5) @(posedge core_clk_in);
        #1;
        check({12'h000, frame_sync_oe_out, serial_clock_oe_out, serial_data_oe_out,
            parallel_data_oe_out}, 16'h0000);
        $display("test parallel done");
        port_type_select_in <= 1'h1;
        chip_select_n_in <= 1'h0;
        for (int d = 0; d < 5; d++) begin
            serial_clock_divider_in <= (d == 4) ? 2'h2 : d[1:0];
            fast_mode_in <= (d < 3);
            low_power_in <= (d == 3);
            repeat (4) @(posedge core_clk_in);
            convert();
            wait_idle();
            check(got, q.pop_front());
            check(nbits[15:0], 16'h0010);
            // Slow dividers only: the two fast ones cannot fit the core clock
            if (d > 1) check(16'(wid <= (d == 3 ? 115 : d == 4 ? 65 : 60)), 16'h1);
        end
        $display("test master done");
        read_timing_select_in <= 1'h1;
        convert();
        wait_idle();
        convert();
        repeat (60) @(posedge core_clk_in);
        check(got, q.pop_front());
        $display("test read during convert done");
        clock_source_select_in <= 1'h1;
        repeat (4) @(posedge core_clk_in);
        nbits = 0;
        run <= 1'h1;
        for (int k = 0; k < 400 && nbits < 16; k++) @(posedge core_clk_in);
        run <= 1'h0;
        check(got, q.pop_front());
        $display("test slave done");
        print_verdict();
    end
endmodule
